// File: design/lmd_cfg_regs.svh
// lmd_cfg_regs.svh: command codes, field positions, reset values,
// write masks and timing counts of the display driver config bank.
// assumes inclusion by bare name from the package and design files.
`ifndef LMD_CFG_REGS_SVH
`define LMD_CFG_REGS_SVH

// serial command codes, 16 bits, sent msb first
`define LMD_CMD_W 16
`define LMD_WR_BASE 16'hAA00
`define LMD_RD_BASE 16'hAA60
`define LMD_IDX_FIRST 4'h1
`define LMD_IDX_LAST 4'h4

// word width and frame bit counts
`define LMD_WORD_W 48
`define LMD_CMD_LAST 6'h0F
`define LMD_WORD_LAST 6'h2F

// segment word field positions
`define LMD_SEG_LSB 0
`define LMD_SEG_W 10
`define LMD_LSW_LSB 37
`define LMD_LSW_W 4
`define LMD_BLK_LSB 41
`define LMD_BLK_W 6

// misc single-bit field positions
`define LMD_SUBP_BIT 42
`define LMD_RB_BIT 7
`define LMD_CUT_BIT 0
`define LMD_CHANNEL_CURRENT_RANGE_BIT 3
`define LMD_REV_BIT 14

// reset values of the four words
`define LMD_RST_SEG 48'h00E0_0094_A400
`define LMD_RST_PDC 48'h0380_0000_0666
`define LMD_RST_BRT 48'h003B_7F7F_7F00
`define LMD_RST_OUT 48'h0800_0540_4000

// writable bits; the rest keep their reset value
`define LMD_MSK_SEG 48'h7FFF_FFFF_FFFF
`define LMD_MSK_PDC 48'h078F_FFFF_FFFF
`define LMD_MSK_BRT 48'hFFFF_FFFF_FFFF
`define LMD_MSK_OUT 48'h1FFF_0FFF_4009

// timing counts in grayscale clocks
`define LMD_SEG_LONG_CODE 10'h3FF
`define LMD_SEG_SHORT 11'h080
`define LMD_SEG_LONG 11'h400
`define LMD_LSW_ZERO 9'h02D
`define LMD_LSW_STEP 9'h01E

`endif

// File: design/lmd_cfg_pkg.sv
// lmd_cfg_pkg: types shared by the config bank.
// assumes the constants header sits beside it.
`include "lmd_cfg_regs.svh"

package lmd_cfg_pkg;

  typedef logic [`LMD_WORD_W-1:0] lmd_word_t;
  typedef logic [1:0] lmd_sel_t;

  typedef enum logic [2:0] {
    LMD_IDLE,
    LMD_CMD,
    LMD_DATA,
    LMD_RDWAIT,
    LMD_RDOUT
  } lmd_link_e;

  // state on the system clock
  typedef struct packed {
    logic [3:0][`LMD_WORD_W-1:0] cfg;
    logic [2:0] wrSync;
    logic [2:0] rdSync;
    logic rdAck;
    lmd_word_t rdHold;
    logic [10:0] segClk;
    logic [8:0] lswClk;
    logic [5:0] blkClk;
    logic [11:0] segTotal;
  } lmd_core_s;

  // state on the link clock
  typedef struct packed {
    logic [1:0] rstSync;
    logic [1:0] lastSync;
    logic [1:0] cutSync;
    logic [2:0] ackSync;
    lmd_link_e state;
    logic [5:0] cnt;
    logic [`LMD_CMD_W-1:0] cmd;
    lmd_word_t shift;
    lmd_sel_t sel;
    logic wrTgl;
    logic rdTgl;
    lmd_word_t wrWord;
    logic serialOut;
  } lmd_link_s;

endpackage

// File: design/lmd_config_bank.sv
// lmd_config_bank: four 48-bit configuration words of a matrix led
// driver, written and read back over the daisy-chained serial link.
// assumes linkClk runs continuously and serial pins change with it.
`timescale 1ns/1ps
`default_nettype none
`include "lmd_cfg_regs.svh"

////////////////////////////////////////////////////////////////////
// Behaviour
// - segment length code 1023 gives 1024 clocks, any other gives 128.
// - line switch code 0 gives 45 clocks, else (code+1)*30; reset 0111b.
// - black field adds code clocks, 0 to 63; reset zero.
// - three smoothing step fields, reset 01001b, code n means level n+1.
// - three enhancement fields reset zero, level equals code.
// - pre-discharge codes reset 0110b; controller keeps voltage in range.
// - three decoupling level fields reset zero, code n means level n+1.
// - three low-gray compensation nibbles reset zero.
// - immunity bit per color, reset 1; zero means high immunity.
// - enable bit raises maximum sub-period count to 256; reset clear.
// - open-load threshold codes per color, reset 00b.
// - fault readback enabled only while its bit is one; reset zero.
// - color brightness bytes reset 7Fh, level equals code.
// - global brightness three bits reset 011b.
// - short removal four bits reset 0111b, code n means level n+1.
// - red short threshold three bits reset zero.
// - green and blue short thresholds three bits reset zero.
// - last device silences serial output when cut-off set, except reads.
// - current range bit picks 10 mA or 20 mA maximum; reset zero.
// - scan reverse bit, reset 1, orders upper lines in stacked use.
// - commands and words arrive serially; words return on serial out.
// - segment time is segment length plus line switch time.
module lmd_config_bank (
  // system clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link
  input wire logic linkClk,
  input wire logic serialIn,
  input wire logic frameSync,
  input wire logic isLastDevice,
  output logic serialOutPin,
  // configuration words
  output lmd_cfg_pkg::lmd_word_t segCfg,
  output lmd_cfg_pkg::lmd_word_t pdcCfg,
  output lmd_cfg_pkg::lmd_word_t brtCfg,
  output lmd_cfg_pkg::lmd_word_t outCfg,
  // decoded timing and controls
  output logic [10:0] segmentClockCount,
  output logic [8:0] lineSwitchTime,
  output logic [5:0] blackFieldAdjust,
  output logic [11:0] segmentTotalClocks,
  output logic subperiodMaxExtend,
  output logic faultReadbackEnable,
  output logic channelCurrentRange,
  output logic scanOrderReverse
);
  import lmd_cfg_pkg::*;

  lmd_core_s core_r;
  lmd_core_s core_nxt;
  lmd_link_s link_r;
  lmd_link_s link_nxt;

  // write masks and resets indexed by word
  localparam logic [3:0][`LMD_WORD_W-1:0] WR_MASK = {
    `LMD_MSK_OUT, `LMD_MSK_BRT, `LMD_MSK_PDC, `LMD_MSK_SEG};
  localparam logic [3:0][`LMD_WORD_W-1:0] RST_VAL = {
    `LMD_RST_OUT, `LMD_RST_BRT, `LMD_RST_PDC, `LMD_RST_SEG};

  //////////////////////////////////////////////////////////////////
  // system clock side: config words, decode, readback holding

  logic wrEvent;
  logic rdEvent;
  logic [`LMD_SEG_W-1:0] segCode;
  logic [`LMD_LSW_W-1:0] lswCode;
  logic [8:0] lswSum;

  // toggle edges after two sync stages; stage 0 feeds stage 1 only
  assign wrEvent = core_r.wrSync[2] ^ core_r.wrSync[1];
  assign rdEvent = core_r.rdSync[2] ^ core_r.rdSync[1];

  always_comb begin
    core_nxt = core_r;
    core_nxt.wrSync = {core_r.wrSync[1:0], link_r.wrTgl};
    core_nxt.rdSync = {core_r.rdSync[1:0], link_r.rdTgl};
    // link holds word and select stable until its next frame
    if (wrEvent) begin
      core_nxt.cfg[link_r.sel] =
        (link_r.wrWord & WR_MASK[link_r.sel]) |
        (RST_VAL[link_r.sel] & ~WR_MASK[link_r.sel]);
    end
    // sample the whole word once, then answer with a toggle
    if (rdEvent) begin
      core_nxt.rdHold = core_r.cfg[link_r.sel];
      core_nxt.rdAck = ~core_r.rdAck;
    end
    if (!resetn) begin
      core_nxt.cfg = RST_VAL;
      core_nxt.rdAck = 1'b0;
      core_nxt.rdHold = '0;
    end
  end

  // decode from the next config so outputs track in one cycle
  always_comb begin
    segCode = core_nxt.cfg[0][`LMD_SEG_LSB +: `LMD_SEG_W];
    lswCode = core_nxt.cfg[0][`LMD_LSW_LSB +: `LMD_LSW_W];
    lswSum = 9'({5'h00, lswCode} + 9'h001);
  end

  lmd_core_s coreDec;
  logic [8:0] lswProd;

  always_comb begin
    lswProd = 9'(lswSum * `LMD_LSW_STEP);
    coreDec = core_nxt;
    coreDec.segClk = (segCode == `LMD_SEG_LONG_CODE) ?
      `LMD_SEG_LONG : `LMD_SEG_SHORT;
    coreDec.lswClk = (lswCode == 4'h0) ?
      `LMD_LSW_ZERO : lswProd;
    coreDec.blkClk =
      core_nxt.cfg[0][`LMD_BLK_LSB +: `LMD_BLK_W];
    coreDec.segTotal = 12'({1'b0, coreDec.segClk} +
      {3'h0, coreDec.lswClk});
  end

  // one register stage for the whole system-side state
  always_ff @(posedge clk) begin
    core_r <= coreDec;
  end

  // outputs straight from the registered state
  assign segCfg = core_r.cfg[0];
  assign pdcCfg = core_r.cfg[1];
  assign brtCfg = core_r.cfg[2];
  assign outCfg = core_r.cfg[3];
  assign segmentClockCount = core_r.segClk;
  assign lineSwitchTime = core_r.lswClk;
  assign blackFieldAdjust = core_r.blkClk;
  assign segmentTotalClocks = core_r.segTotal;
  assign subperiodMaxExtend = core_r.cfg[1][`LMD_SUBP_BIT];
  assign faultReadbackEnable = core_r.cfg[2][`LMD_RB_BIT];
  assign channelCurrentRange = core_r.cfg[3][`LMD_CHANNEL_CURRENT_RANGE_BIT];
  assign scanOrderReverse = core_r.cfg[3][`LMD_REV_BIT];

  //////////////////////////////////////////////////////////////////
  // link clock side: command and word shifting

  logic linkRst;
  logic ackEvent;
  logic cutActive;
  logic cmdIsWr;
  logic cmdIsRd;
  logic idxOk;
  logic [`LMD_CMD_W-1:0] cmdFull;

  assign linkRst = ~link_r.rstSync[1];
  assign ackEvent = link_r.ackSync[2] ^ link_r.ackSync[1];
  // cut only bites on the last device of the chain
  assign cutActive = link_r.cutSync[1] & link_r.lastSync[1];
  assign cmdFull = {link_r.cmd[`LMD_CMD_W-2:0], serialIn};
  assign idxOk = (cmdFull[3:0] >= `LMD_IDX_FIRST) &&
    (cmdFull[3:0] <= `LMD_IDX_LAST);
  assign cmdIsWr = idxOk &&
    (cmdFull[`LMD_CMD_W-1:4] == `LMD_WR_BASE >> 4);
  assign cmdIsRd = idxOk &&
    (cmdFull[`LMD_CMD_W-1:4] == `LMD_RD_BASE >> 4);

  always_comb begin
    link_nxt = link_r;
    link_nxt.rstSync = {link_r.rstSync[0], resetn};
    link_nxt.lastSync = {link_r.lastSync[0], isLastDevice};
    link_nxt.cutSync = {link_r.cutSync[0],
      core_r.cfg[3][`LMD_CUT_BIT]};
    link_nxt.ackSync = {link_r.ackSync[1:0], core_r.rdAck};
    link_nxt.cnt = 6'(link_r.cnt + 6'h01);
    // pass-through by default, silenced on a cut last device
    link_nxt.serialOut = cutActive ? 1'b0 : serialIn;
    case (link_r.state)
      LMD_IDLE: begin
        link_nxt.cnt = 6'h00;
      end
      LMD_CMD: begin
        link_nxt.cmd = cmdFull;
        if (link_r.cnt == `LMD_CMD_LAST) begin
          link_nxt.cnt = 6'h00;
          link_nxt.sel = 2'(cmdFull[3:0] - 4'h1);
          if (cmdIsWr) begin
            link_nxt.state = LMD_DATA;
          end else if (cmdIsRd) begin
            link_nxt.state = LMD_RDWAIT;
            link_nxt.rdTgl = ~link_r.rdTgl;
          end else begin
            link_nxt.state = LMD_IDLE;
          end
        end
      end
      LMD_DATA: begin
        link_nxt.shift = {link_r.shift[`LMD_WORD_W-2:0], serialIn};
        if (link_r.cnt == `LMD_WORD_LAST) begin
          // word stays put until the next write frame ends
          link_nxt.wrWord = {link_r.shift[`LMD_WORD_W-2:0], serialIn};
          link_nxt.wrTgl = ~link_r.wrTgl;
          link_nxt.state = LMD_IDLE;
        end
      end
      LMD_RDWAIT: begin
        link_nxt.cnt = 6'h00;
        if (ackEvent) begin
          link_nxt.shift = core_r.rdHold;
          link_nxt.state = LMD_RDOUT;
        end
      end
      LMD_RDOUT: begin
        // reads drive out even when the cut-off is set
        link_nxt.serialOut = link_r.shift[`LMD_WORD_W-1];
        link_nxt.shift = {link_r.shift[`LMD_WORD_W-2:0], 1'b0};
        if (link_r.cnt == `LMD_WORD_LAST) begin
          link_nxt.state = LMD_IDLE;
        end
      end
      default: begin
        link_nxt.state = LMD_IDLE;
      end
    endcase
    // a new frame restarts the command shift from any state
    if (frameSync) begin
      link_nxt.state = LMD_CMD;
      link_nxt.cnt = 6'h01;
      link_nxt.cmd = {{(`LMD_CMD_W-1){1'b0}}, serialIn};
    end
    if (linkRst) begin
      link_nxt.state = LMD_IDLE;
      link_nxt.cnt = 6'h00;
      link_nxt.cmd = '0;
      link_nxt.shift = '0;
      link_nxt.sel = 2'h0;
      link_nxt.wrTgl = 1'b0;
      link_nxt.rdTgl = 1'b0;
      link_nxt.wrWord = '0;
      link_nxt.serialOut = 1'b0;
    end
  end

  // one register stage for the whole link-side state
  always_ff @(posedge linkClk) begin
    link_r <= link_nxt;
  end

  assign serialOutPin = link_r.serialOut;

endmodule

`default_nettype wire

// File: test/lmd_config_bank_assertions.sv
// lmd_config_bank_assertions: port checks of the config bank.
// assumes one clk domain and the constants header on the path.
`timescale 1ns/1ps
`default_nettype none
`include "lmd_cfg_regs.svh"
module lmd_config_bank_assertions
  import lmd_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // words
  input wire lmd_word_t segCfg,
  input wire lmd_word_t pdcCfg,
  input wire lmd_word_t brtCfg,
  input wire lmd_word_t outCfg,
  // decoded
  input wire logic [10:0] segmentClockCount,
  input wire logic [8:0] lineSwitchTime,
  input wire logic [5:0] blackFieldAdjust,
  input wire logic [11:0] segmentTotalClocks,
  input wire logic subperiodMaxExtend,
  input wire logic faultReadbackEnable,
  input wire logic channelCurrentRange,
  input wire logic scanOrderReverse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // decoded timing follows the segment word on the same edge
  AST_SEG_LEN: assert property (
    segmentClockCount == (segCfg[9:0] == 10'h3FF ? 11'h400 : 11'h080))
    else $error("segment count mismatch");
  AST_LINE_SW: assert property (
    lineSwitchTime == (segCfg[40:37] == 4'h0 ? 9'h02D :
      9'h01E * (9'(segCfg[40:37]) + 9'h001)))
    else $error("line switch mismatch");
  AST_BLACK: assert property (
    blackFieldAdjust == segCfg[46:41]) else $error("black field mismatch");
  AST_TOTAL: assert property (
    segmentTotalClocks == 12'(segmentClockCount) + 12'(lineSwitchTime))
    else $error("segment total mismatch");
  // single control bits mirror their word bits
  AST_SUBP: assert property (
    subperiodMaxExtend == pdcCfg[42]) else $error("subperiod mismatch");
  AST_RDBK: assert property (
    faultReadbackEnable == brtCfg[7]) else $error("readback mismatch");
  AST_CHANNEL_CURRENT_RANGE: assert property (
    channelCurrentRange == outCfg[3]) else $error("current mismatch");
  AST_REV: assert property (
    scanOrderReverse == outCfg[14]) else $error("scan order mismatch");
  // read-only bits never move away from their reset value
  AST_RSV_BITS: assert property (
    ((segCfg ^ `LMD_RST_SEG) & ~`LMD_MSK_SEG) == '0 &&
    ((pdcCfg ^ `LMD_RST_PDC) & ~`LMD_MSK_PDC) == '0 &&
    ((outCfg ^ `LMD_RST_OUT) & ~`LMD_MSK_OUT) == '0)
    else $error("reserved bit changed");
  AST_RST_VAL: assert property (disable iff (1'b0)
    !resetn |=> brtCfg == `LMD_RST_BRT && pdcCfg == `LMD_RST_PDC)
    else $error("reset value wrong");
  // main scenarios reached
  COV_LONG: cover property (segmentClockCount == 11'h400);
  COV_RDBK: cover property (faultReadbackEnable);
  COV_FWD: cover property (!scanOrderReverse);
endmodule
bind lmd_config_bank lmd_config_bank_assertions u_chk (.*);
`default_nettype wire

// File: test/lmd_ctrl_model.sv
// lmd_ctrl_model: display controller end of the serial chain.
// assumes linkClk free-running from the bench.
`timescale 1ns/1ps
`default_nettype none
module lmd_ctrl_model (
  // link
  input wire logic linkClk,
  input wire logic serialOutPin,
  output logic serialIn,
  output logic frameSync
);
  logic [79:0] cap;
  initial begin
    serialIn = 1'b0;
    frameSync = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one frame: 16-bit command then n data bits, msb first
  task automatic send(input logic [15:0] cmd, input logic [47:0] d,
                      input int n);
    logic [63:0] f;
    f = {cmd, d};
    for (int i = 0; i < 16 + n; i++) begin
      @(posedge linkClk);
      #1;
      frameSync = (i == 0);
      serialIn = f[63-i];
    end
  endtask
  // idle toggles the input so stale data never looks valid
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge linkClk);
      #1;
      // sample after the edge so the bit just launched has settled
      cap = {cap[78:0], serialOutPin};
      frameSync = 1'b0;
      serialIn = ~serialIn;
    end
  endtask
endmodule
`default_nettype wire

// File: test/test_lmd_config_bank.sv
// test_lmd_config_bank: serial writes and readbacks of the bank.
// assumes controller model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "lmd_cfg_regs.svh"
module test_lmd_config_bank;
  import lmd_cfg_pkg::*;
  logic clk, resetn, linkClk, isLastDevice, serialIn, frameSync;
  logic serialOutPin, subperiodMaxExtend, faultReadbackEnable;
  logic channelCurrentRange, scanOrderReverse;
  lmd_word_t segCfg, pdcCfg, brtCfg, outCfg;
  logic [10:0] segmentClockCount;
  logic [8:0] lineSwitchTime;
  logic [5:0] blackFieldAdjust;
  logic [11:0] segmentTotalClocks;
  logic [3:0][47:0] cw;
  int errors = 0, n_checks = 0, cyc = 0;
  lmd_word_t rstV [4] = '{`LMD_RST_SEG, `LMD_RST_PDC,
                          `LMD_RST_BRT, `LMD_RST_OUT};
  lmd_word_t mskV [4] = '{`LMD_MSK_SEG, `LMD_MSK_PDC,
                          `LMD_MSK_BRT, `LMD_MSK_OUT};
  // pdc codes stay at zero: lowest voltage is safe on any supply
  lmd_word_t patV [4] = '{'1, 48'hFFFF_FFFF_F000, '1, '1};
  lmd_config_bank u_dut (.*);
  lmd_ctrl_model u_ctrl (.*);
  assign cw = {outCfg, brtCfg, pdcCfg, segCfg};
  ////////////////////////////////////////////////////////////////
  // clocks: link runs free and out of phase with clk
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #32 linkClk = ~linkClk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      end_sim();
    end
  end
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic lmd_word_t expw(input int i, input lmd_word_t d);
    return (rstV[i] & ~mskV[i]) | (d & mskV[i]);
  endfunction
  // write, then leave well over 8 clk before the next frame
  task automatic wr(input int i, input lmd_word_t d);
    u_ctrl.send(`LMD_WR_BASE | 16'(i + 1), d, 48);
    u_ctrl.idle(12);
  endtask
  // answer start is not fixed, so search the capture for the word
  task automatic rd(input int i, input lmd_word_t exp);
    logic hit;
    hit = 1'b0;
    u_ctrl.send(`LMD_RD_BASE | 16'(i + 1), '0, 0);
    u_ctrl.idle(80);
    for (int k = 0; k <= 32; k++)
      if (u_ctrl.cap[k+:48] === exp) hit = 1'b1;
    check(hit, 1'b1);
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    isLastDevice = 1'b0;
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    u_ctrl.idle(8);
    for (int i = 0; i < 4; i++) check(cw[i], rstV[i]);
    check(lineSwitchTime, 9'h0F0);
    check(scanOrderReverse, 1'b1);
    // full writes: reserved bits hold, readback matches
    for (int i = 0; i < 4; i++) begin
      wr(i, patV[i]);
      check(cw[i], expw(i, patV[i]));
      rd(i, expw(i, patV[i]));
    end
    check(segmentClockCount, 11'h400);
    check(lineSwitchTime, 9'h1E0);
    check(blackFieldAdjust, 6'h3F);
    check(subperiodMaxExtend, 1'b1);
    check({faultReadbackEnable, channelCurrentRange}, 2'h3);
    // code 127 gives the short segment, code 0 the 45-clock switch
    wr(0, 48'h0000_0000_007F);
    check(segmentClockCount, 11'h080);
    check(lineSwitchTime, 9'h02D);
    check(segmentTotalClocks, 12'h0AD);
    // cut-off set: last device silent except for read answers
    @(posedge clk) #1 isLastDevice = 1'b1;
    u_ctrl.idle(24);
    check(u_ctrl.cap[15:0], 16'h0000);
    rd(3, expw(3, '1));
    @(posedge clk) #1 isLastDevice = 1'b0;
    u_ctrl.idle(24);
    check(u_ctrl.cap[15:0], u_ctrl.cap[0] ? 16'h5555 : 16'hAAAA);
    wr(3, '0);
    check(scanOrderReverse, 1'b0);
    // second reset in mid-run brings every word back to its reset value
    @(posedge clk) #1 resetn = 1'b0;
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    u_ctrl.idle(8);
    for (int i = 0; i < 4; i++) check(cw[i], rstV[i]);
    check(scanOrderReverse, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
